// >>> logic/pump_channel_sequencer.sv
// Purpose: one pump channel sequencer with register port
// Assumes: rev_pulse marks each completed full revolution
// Notes:   pins except fault_elsewhere pass two flip-flops before use
//
// The register addresses and the plain strobed port were left to the implementer.
`include "pump_seq_params.svh"
`default_nettype none
module pump_channel_sequencer #(
   parameter int MS_CYCLES   = `MS_CYCLES,
   parameter int BAUD_CYCLES = `BAUD_CYCLES
) (
   input  wire logic                     clk_sys,
   input  wire logic                     rstn,
   input  wire logic [3:0]               addr,
   input  wire logic [15:0]              wdata,
   input  wire logic                     wr,
   input  wire logic                     rd,
   output logic [15:0]                   rdata,
   input  wire logic                     contact_trigger_input,
   input  wire logic                     plc_trigger,
   input  wire logic                     panel_disable_position,
   input  wire logic                     home_sensor,
   input  wire logic                     rev_pulse,
   input  wire logic                     chamber_empty,
   input  wire logic                     motor_fault,
   input  wire logic                     fault_elsewhere,
   output pump_seq_pkg::motor_cmd_t      motor_cmd,
   output logic                          ready,
   output logic                          baud_tick
);
   import pump_seq_pkg::*;

   // refused at elaboration: counters cannot serve these counts
   if (MS_CYCLES < 2 || MS_CYCLES > 65535 * 16 || BAUD_CYCLES < 2 || BAUD_CYCLES > 65535) begin : g_bad_timing
      $error("pump_channel_sequencer: timing parameter out of range");
   end

   // reset release
   logic [1:0] rst_sync_reg;
   logic       rst_n;
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) rst_sync_reg <= 2'b00;
      else rst_sync_reg <= {rst_sync_reg[0], 1'b1};
   end
   assign rst_n = rst_sync_reg[1];

   // pin synchronisers, one generate per pin
   localparam int NPIN = 7;
   logic [NPIN-1:0] pin_raw;
   logic [NPIN-1:0] pin_s1_reg;
   logic [NPIN-1:0] pin_s2_reg;
   assign pin_raw = {contact_trigger_input, plc_trigger, panel_disable_position,
                     home_sensor, rev_pulse, chamber_empty, motor_fault};
   genvar gi;
   generate
      for (gi = 0; gi < NPIN; gi++) begin : g_sync
         always_ff @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
               pin_s1_reg[gi] <= 1'b0;
               pin_s2_reg[gi] <= 1'b0;
            end else begin
               pin_s1_reg[gi] <= pin_raw[gi];
               pin_s2_reg[gi] <= pin_s1_reg[gi];
            end
         end
      end
   endgenerate

   logic contact_s, plc_s, panel_disable_position_s, home_s, rev_s, empty_s, mfault_s;
   assign {contact_s, plc_s, panel_disable_position_s, home_s, rev_s, empty_s, mfault_s} = pin_s2_reg;

   // edge history, read only from the second stage
   logic trig_d_reg, rev_d_reg;
   logic trig, trig_rise, rev_edge;
   assign trig      = contact_s | plc_s;
   assign trig_rise = trig & ~trig_d_reg;
   assign rev_edge  = rev_s & ~rev_d_reg;

   // registers
   ctrl_t       ctrl_reg;
   logic [15:0] volume_reg, rate_dm_reg, rate_prime_reg, prime_lim_reg;
   logic [15:0] db_volume_reg, db_rate_reg, db_dwell_reg;
   logic [15:0] total_reg, fault_id_reg, cleared_id_reg;
   logic        fault_reg, ref_ok_reg, reject_reg;
   seq_state_t  state_reg, state_next;
   logic [15:0] rev_cnt_reg, ms_cnt_reg;
   logic [31:0] tick_cnt_reg;
   logic [15:0] baud_cnt_reg;
   logic        by_serial_reg;

   // decode
   logic wr_ctrl, wr_cmd;
   logic cmd_begin, cmd_end, cmd_ref, cmd_clear, cmd_clr_tot;
   assign wr_ctrl     = wr && addr == `ADDR_CTRL;
   assign wr_cmd      = wr && addr == `ADDR_COMMAND;
   assign cmd_begin   = wr_cmd & wdata[`CMD_BEGIN];
   assign cmd_end     = wr_cmd & wdata[`CMD_END];
   assign cmd_ref     = wr_cmd & wdata[`CMD_REFERENCE];
   assign cmd_clear   = wr_cmd & wdata[`CMD_CLEAR_FAULT];
   assign cmd_clr_tot = wr_cmd & wdata[`CMD_CLEAR_TOTAL];

   // motion gating
   logic idle, may_move, may_ref;
   logic start_prime, start_disp, start_meter, start_ref, motion_req;
   assign idle     = state_reg == ST_IDLE;
   assign may_ref  = ~fault_reg & ctrl_reg.enable & idle;
   assign may_move = may_ref & ref_ok_reg;
   assign start_prime = may_move & ctrl_reg.mode == `MODE_PRIME & cmd_begin;
   assign start_disp  = may_move & ctrl_reg.mode == `MODE_DISPENSE & (cmd_begin | trig_rise);
   assign start_meter = may_move & ctrl_reg.mode == `MODE_METER & (cmd_begin | trig_rise)
                        & ~empty_s;
   assign start_ref   = may_ref & cmd_ref;
   assign motion_req  = cmd_begin | cmd_ref;

   logic [16:0] fwd_target;
   assign fwd_target = {1'b0, volume_reg} + {1'b0, db_volume_reg};

   logic ms_tick, prime_over, dwell_over, fwd_done, db_done, meter_stop, db_on;
   assign ms_tick    = tick_cnt_reg == 32'(MS_CYCLES - 1);
   assign prime_over = ms_cnt_reg >= prime_lim_reg;
   assign dwell_over = ms_cnt_reg >= db_dwell_reg;
   assign fwd_done   = {1'b0, rev_cnt_reg} >= fwd_target;
   assign db_done    = rev_cnt_reg >= db_volume_reg;
   assign meter_stop = empty_s | (~by_serial_reg & ~trig);
   assign db_on      = db_volume_reg != 16'h0000;

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE: begin
            if (start_ref) state_next = ST_HOMING;
            else if (start_prime) state_next = ST_PRIME;
            else if (start_disp) state_next = ST_FORWARD;
            else if (start_meter) state_next = ST_METER;
         end
         ST_HOMING:   if (home_s) state_next = ST_IDLE;
         ST_PRIME:    if (cmd_end | prime_over) state_next = ST_IDLE;
         ST_FORWARD: begin
            if (cmd_end) state_next = ST_IDLE;
            else if (fwd_done) state_next = db_on ? ST_DWELL : ST_IDLE;
         end
         ST_METER: begin
            if (cmd_end | meter_stop) state_next = db_on ? ST_DWELL : ST_IDLE;
         end
         ST_DWELL:    if (dwell_over) state_next = ST_DRAWBACK;
         ST_DRAWBACK: if (db_done) state_next = ST_IDLE;
         default:     state_next = ST_IDLE;
      endcase
      if (fault_reg) state_next = ST_IDLE;
   end

   // motor command
   motor_cmd_t mcmd_next;
   always_comb begin
      mcmd_next.run     = 1'b0;
      mcmd_next.reverse = ctrl_reg.reverse;
      mcmd_next.rate    = rate_dm_reg;
      case (state_next)
         ST_HOMING:   mcmd_next.run = 1'b1;
         ST_PRIME: begin
            mcmd_next.run  = 1'b1;
            mcmd_next.rate = rate_prime_reg;
         end
         ST_FORWARD, ST_METER: mcmd_next.run = 1'b1;
         ST_DRAWBACK: begin
            mcmd_next.run     = 1'b1;
            mcmd_next.reverse = ~ctrl_reg.reverse;
            mcmd_next.rate    = db_rate_reg;
         end
         default:     mcmd_next.run = 1'b0;
      endcase
   end

   logic phase_change;
   assign phase_change = state_next != state_reg;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_reg     <= ST_IDLE;
         motor_cmd     <= '0;
         trig_d_reg    <= 1'b0;
         rev_d_reg     <= 1'b0;
         by_serial_reg <= 1'b0;
      end else begin
         state_reg     <= state_next;
         motor_cmd     <= mcmd_next;
         trig_d_reg    <= trig;
         rev_d_reg     <= rev_s;
         if (idle) by_serial_reg <= cmd_begin;
      end
   end

   // phase counters restart on each phase change
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rev_cnt_reg  <= 16'h0000;
         ms_cnt_reg   <= 16'h0000;
         tick_cnt_reg <= 32'h0000_0000;
      end else if (phase_change) begin
         rev_cnt_reg  <= 16'h0000;
         ms_cnt_reg   <= 16'h0000;
         tick_cnt_reg <= 32'h0000_0000;
      end else begin
         if (rev_edge && rev_cnt_reg != `TOTAL_MAX) rev_cnt_reg <= rev_cnt_reg + 16'h0001;
         tick_cnt_reg <= ms_tick ? 32'h0000_0000 : tick_cnt_reg + 32'h0000_0001;
         if (ms_tick && ms_cnt_reg != `TOTAL_MAX) ms_cnt_reg <= ms_cnt_reg + 16'h0001;
      end
   end

   // totalizer
   logic tot_count;
   assign tot_count = rev_edge & (state_reg == ST_FORWARD | state_reg == ST_METER);
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) total_reg <= 16'h0000;
      else if (cmd_clr_tot) total_reg <= 16'h0000;
      else if (tot_count && total_reg != `TOTAL_MAX) total_reg <= total_reg + 16'h0001;
   end

   // fault, reference and warning state
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         fault_reg      <= 1'b0;
         fault_id_reg   <= 16'h0000;
         cleared_id_reg <= 16'h0000;
         ref_ok_reg     <= 1'b0;
         reject_reg     <= 1'b0;
      end else begin
         if (mfault_s) begin
            fault_reg    <= 1'b1;
            fault_id_reg <= `FAULT_MOTOR;
         end else if (cmd_clear) begin
            fault_reg    <= 1'b0;
            fault_id_reg <= 16'h0000;
         end
         if (cmd_clear) cleared_id_reg <= fault_id_reg;
         if (mfault_s) ref_ok_reg <= 1'b0;
         else if (start_ref) ref_ok_reg <= 1'b1;
         if (motion_req) reject_reg <= ~(start_ref | start_prime | start_disp | start_meter);
      end
   end

   // parameter registers
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_reg       <= `CTRL_RESET;
         volume_reg     <= 16'h0000;
         rate_dm_reg    <= 16'h0000;
         rate_prime_reg <= 16'h0000;
         prime_lim_reg  <= 16'h0000;
         db_volume_reg  <= 16'h0000;
         db_rate_reg    <= 16'h0000;
         db_dwell_reg   <= 16'h0000;
      end else if (wr) begin
         case (addr)
            `ADDR_CTRL: begin
               ctrl_reg.mode    <= wdata[1:0];
               ctrl_reg.reverse <= wdata[2];
               ctrl_reg.enable  <= wdata[3] & ~panel_disable_position_s;
            end
            `ADDR_VOLUME:     volume_reg     <= wdata;
            `ADDR_RATE_DM:    rate_dm_reg    <= wdata;
            `ADDR_RATE_PRIME: rate_prime_reg <= wdata;
            `ADDR_PRIME_LIM:  prime_lim_reg  <= wdata;
            `ADDR_DB_VOLUME:  db_volume_reg  <= wdata;
            `ADDR_DB_RATE:    db_rate_reg    <= wdata;
            `ADDR_DB_DWELL:   db_dwell_reg   <= wdata;
            default:          ctrl_reg       <= ctrl_reg;
         endcase
      end
   end

   // read path; panel and fault-elsewhere bits are live, fault and reject bits hold until clear or the next begin/reference
   logic [15:0] status_word, rd_mux;
   assign status_word = {7'h00, state_reg, panel_disable_position_s, reject_reg, ~ref_ok_reg,
                         fault_elsewhere, fault_reg, ~idle};
   always_comb begin
      case (addr)
         `ADDR_CTRL:       rd_mux = {12'h000, ctrl_reg};
         `ADDR_VOLUME:     rd_mux = volume_reg;
         `ADDR_RATE_DM:    rd_mux = rate_dm_reg;
         `ADDR_RATE_PRIME: rd_mux = rate_prime_reg;
         `ADDR_PRIME_LIM:  rd_mux = prime_lim_reg;
         `ADDR_DB_VOLUME:  rd_mux = db_volume_reg;
         `ADDR_DB_RATE:    rd_mux = db_rate_reg;
         `ADDR_DB_DWELL:   rd_mux = db_dwell_reg;
         `ADDR_STATUS:     rd_mux = status_word;
         `ADDR_TOTAL:      rd_mux = total_reg;
         `ADDR_FAULT_ID:   rd_mux = cleared_id_reg;
         default:          rd_mux = 16'h0000;
      endcase
   end
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) rdata <= 16'h0000;
      else if (rd) rdata <= rd_mux;
      else rdata <= 16'h0000;
   end

   assign ready = idle;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         baud_cnt_reg <= 16'h0000;
         baud_tick    <= 1'b0;
      end else begin
         baud_tick    <= baud_cnt_reg == 16'(BAUD_CYCLES - 1);
         baud_cnt_reg <= baud_cnt_reg == 16'(BAUD_CYCLES - 1) ? 16'h0000 : baud_cnt_reg + 16'h0001;
      end
   end

   // checks
   sequence s_fwd_end;
      state_reg == ST_FORWARD && !cmd_end && fwd_done && !fault_reg;
   endsequence

   property p_prime_no_trigger;
      @(posedge clk_sys) disable iff (!rst_n)
      idle && !cmd_begin && !cmd_ref |=> state_reg != ST_PRIME;
   endproperty
   a_prime_no_trigger: assert property (p_prime_no_trigger) else $error("prime started without begin");

   property p_prime_limit;
      @(posedge clk_sys) disable iff (!rst_n)
      state_reg == ST_PRIME && prime_over |=> idle;
   endproperty
   a_prime_limit: assert property (p_prime_limit) else $error("prime ran past limit");

   property p_no_prime_total;
      @(posedge clk_sys) disable iff (!rst_n)
      state_reg == ST_PRIME && !cmd_clr_tot |=> $stable(total_reg);
   endproperty
   a_no_prime_total: assert property (p_no_prime_total) else $error("prime changed totalizer");

   property p_dispense_end;
      @(posedge clk_sys) disable iff (!rst_n)
      s_fwd_end |=> (db_on ? state_reg == ST_DWELL : idle) ##1 !motor_cmd.run || state_reg != ST_IDLE;
   endproperty
   a_dispense_end: assert property (p_dispense_end) else $error("dispense missed its volume");

   property p_meter_empty;
      @(posedge clk_sys) disable iff (!rst_n)
      state_reg == ST_METER && empty_s && !fault_reg |=> state_reg != ST_METER;
   endproperty
   a_meter_empty: assert property (p_meter_empty) else $error("meter ran on empty chamber");

   property p_prime_rate;
      @(posedge clk_sys) disable iff (!rst_n)
      state_reg == ST_PRIME |-> motor_cmd.run && motor_cmd.rate == $past(rate_prime_reg)
                                && motor_cmd.reverse == $past(ctrl_reg.reverse);
   endproperty
   a_prime_rate: assert property (p_prime_rate) else $error("prime rate or direction wrong");

   property p_need_ref;
      @(posedge clk_sys) disable iff (!rst_n)
      !ref_ok_reg && idle |=> state_reg == ST_IDLE || state_reg == ST_HOMING;
   endproperty
   a_need_ref: assert property (p_need_ref) else $error("motion before reference");

   property p_drawback_rev;
      @(posedge clk_sys) disable iff (!rst_n)
      state_reg == ST_DRAWBACK |-> motor_cmd.reverse != $past(ctrl_reg.reverse)
                                   && motor_cmd.rate == $past(db_rate_reg);
   endproperty
   a_drawback_rev: assert property (p_drawback_rev) else $error("drawback not reversed");

   property p_panel_disable_position;
      @(posedge clk_sys) disable iff (!rst_n)
      wr_ctrl && panel_disable_position_s |=> !ctrl_reg.enable;
   endproperty
   a_panel_disable_position: assert property (p_panel_disable_position) else $error("enable accepted in panel_disable_position");

   property p_total_sat;
      @(posedge clk_sys) disable iff (!rst_n)
      !cmd_clr_tot |=> total_reg >= $past(total_reg);
   endproperty
   a_total_sat: assert property (p_total_sat) else $error("totalizer wrapped");

   property p_fault_hold;
      @(posedge clk_sys) disable iff (!rst_n)
      fault_reg && !cmd_clear |=> fault_reg ##1 idle;
   endproperty
   a_fault_hold: assert property (p_fault_hold) else $error("fault dropped or motion kept");
endmodule // pump_channel_sequencer
`default_nettype wire

// >>> logic/pump_seq_params.svh
// What this block does
// - trigger is contact input OR plc trigger
// - prime starts on serial begin only
// - prime runs until end or time limit
// - prime revolutions never reach the totalizer
// - dispense starts on begin or trigger
// - dispense stops at volume or end
// - dispense and meter revolutions are totalized
// - meter pumps while trigger, stops empty
// - meter also obeys begin and end
// - direction follows stored direction setting
// - prime rate, shared dispense/meter rate
// - reference turns until home, then stops
// - motion rejected until reference initiated
// - forward stroke is volume plus drawback
// - stop, dwell, reverse at drawback rate
// - enable refused while panel locked out
// - totalizer saturates, readable, clearable
// - fault and reject latched, other warnings only while present
// - fault elsewhere flagged without details
// - fault blocks motion until clear faults
// - 9600 baud tick only; no serial link or 8N1 framing
// Purpose: offsets, fields and timing counts of the pump sequencer
// Assumes: 50 MHz system clock
// Notes:   register index is the address on the plain port
`ifndef PUMP_SEQ_PARAMS_SVH
`define PUMP_SEQ_PARAMS_SVH
`define CLK_HZ          50000000
`define TIME_BASE_US    1000
`define MS_CYCLES       (`CLK_HZ / 1000000 * `TIME_BASE_US)
`define BAUD_RATE       9600
`define BAUD_CYCLES     (`CLK_HZ / `BAUD_RATE)
`define ADDR_CTRL       4'h0
`define ADDR_VOLUME     4'h1
`define ADDR_RATE_DM    4'h2
`define ADDR_RATE_PRIME 4'h3
`define ADDR_PRIME_LIM  4'h4
`define ADDR_DB_VOLUME  4'h5
`define ADDR_DB_RATE    4'h6
`define ADDR_DB_DWELL   4'h7
`define ADDR_COMMAND    4'h8
`define ADDR_STATUS     4'h9
`define ADDR_TOTAL      4'hA
`define ADDR_FAULT_ID   4'hB
`define MODE_PRIME      2'h0
`define MODE_DISPENSE   2'h1
`define MODE_METER      2'h2
`define CMD_BEGIN       0
`define CMD_END         1
`define CMD_REFERENCE   2
`define CMD_CLEAR_FAULT 3
`define CMD_CLEAR_TOTAL 4
`define FAULT_MOTOR     16'h0001
`define TOTAL_MAX       16'hFFFF
`define CTRL_RESET      4'h0
`endif

// >>> logic/pump_seq_pkg.sv
// Purpose: types shared by the pump sequencer
// Assumes: nothing
// Notes:   none
`default_nettype none
package pump_seq_pkg;
   typedef enum logic [2:0] {
      ST_IDLE, ST_HOMING, ST_PRIME, ST_FORWARD, ST_METER, ST_DWELL, ST_DRAWBACK
   } seq_state_t;
   typedef struct packed {
      logic       enable;
      logic       reverse;
      logic [1:0] mode;
   } ctrl_t;
   typedef struct packed {
      logic        run;
      logic        reverse;
      logic [15:0] rate;
   } motor_cmd_t;
endpackage
`default_nettype wire

// >>> tb/motor_base_model.sv
// Purpose: motor/base stand-in turning while the run command is high
// Assumes: one revolution is eight phase steps
// Notes:   slow halves the speed; stopping drops any partial turn
`default_nettype none
module motor_base_model (
   input  wire logic                     clk_sys,
   input  wire pump_seq_pkg::motor_cmd_t motor_cmd,
   input  wire logic                     slow,
   output logic                          rev_pulse,
   output logic                          home_sensor
);
   timeunit 1ns;
   timeprecision 1ps;
   import pump_seq_pkg::*;
   logic [2:0] phase_reg = 3'h0;
   logic       half_reg  = 1'b0;
   always_ff @(posedge clk_sys) begin
      half_reg <= ~half_reg;
      if (!motor_cmd.run) begin
         phase_reg <= 3'h0;
      end else if (!slow || half_reg) begin
         phase_reg <= phase_reg + 3'h1;
      end
   end
   // pulse high 4 steps, low 4 steps
   assign rev_pulse   = phase_reg[2];
   // home seen for two steps, wide enough for the synchroniser
   assign home_sensor = (phase_reg >= 3'h6);
endmodule // motor_base_model
`default_nettype wire

// >>> tb/tb.sv
// Purpose: self-checking bench for the pump channel sequencer
// Assumes: 10 cycles per ms, 8 cycles per baud tick
// Notes:   read data checked one cycle after the strobe
`include "pump_seq_params.svh"
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import pump_seq_pkg::*;
   logic        clk_sys = 0, rstn = 0, wr = 0, rd = 0, rd_q = 0, slow = 0;
   logic        ctc = 0, plc = 0, lock = 0, empty = 0, mfault = 0, felse = 0;
   logic [3:0]  addr = 4'h0;
   logic [15:0] wdata = 16'h0000, tot = 16'h0000, rdata;
   logic        rev_pulse, home_sensor, ready, baud_tick;
   motor_cmd_t  motor_cmd;
   logic [31:0] expq[$];
   logic [31:0] qv;
   int          n_fail = 0, n_compared = 0, cyc = 0, gap = 0, nw = 0;

   pump_channel_sequencer #(.MS_CYCLES(10), .BAUD_CYCLES(8)) u_dut (
      .clk_sys(clk_sys), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .contact_trigger_input(ctc), .plc_trigger(plc), .panel_disable_position(lock),
      .home_sensor(home_sensor), .rev_pulse(rev_pulse), .chamber_empty(empty), .motor_fault(mfault),
      .fault_elsewhere(felse), .motor_cmd(motor_cmd), .ready(ready), .baud_tick(baud_tick));
   motor_base_model u_motor (.clk_sys(clk_sys), .motor_cmd(motor_cmd), .slow(slow),
      .rev_pulse(rev_pulse), .home_sensor(home_sensor));

   initial begin
      forever #10 clk_sys = ~clk_sys;
   end

   task automatic close_out();
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [17:0] e, input logic [17:0] g);
      n_compared++;
      if (g !== e) begin
         n_fail++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
   endtask

   task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk_sys);
      wr    <= 1'b0;
   endtask

   // the expected word goes in with its mask; the watcher pops it
   task automatic rd_reg(input logic [3:0] a, input logic [15:0] e, input logic [15:0] m);
      @(posedge clk_sys);
      expq.push_back({m, e});
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk_sys);
      rd   <= 1'b0;
   endtask

   task automatic wait_ready(input logic v, input int lim);
      nw = 0;
      do begin
         @(negedge clk_sys);
         nw++;
      end while (ready !== v && nw < lim);
      chk("ready", {17'h0, v}, {17'h0, ready});
   endtask

   // read watcher, baud spacing and hang guard
   always @(posedge clk_sys) begin
      rd_q <= rd;
      cyc  <= cyc + 1;
      if (rd_q) begin
         qv = expq.pop_front();
         chk("rdata", {2'b00, qv[15:0]}, {2'b00, rdata & qv[31:16]});
      end
      if (baud_tick) begin
         gap <= 1;
         if (gap != 0) chk("baud gap", 18'd8, 18'(gap));
      end else if (gap != 0) begin
         gap <= gap + 1;
      end
      if (cyc == 60000) begin
         n_fail++;
         close_out();
      end
   end

   initial begin
      int vol;
      int db;
      void'($urandom(63023));
      tick(8);
      rstn <= 1'b1;
      tick(4);
      rd_reg(`ADDR_STATUS, 16'h0008, 16'h01EF);
      wr_reg(`ADDR_CTRL, 16'h0009);
      wr_reg(`ADDR_COMMAND, 16'h0001);
      rd_reg(`ADDR_STATUS, 16'h0018, 16'h0019);
      lock <= 1'b1;
      tick(5);
      wr_reg(`ADDR_CTRL, 16'h0009);
      rd_reg(`ADDR_CTRL, 16'h0001, 16'h000F);
      rd_reg(`ADDR_STATUS, 16'h0020, 16'h0020);
      lock <= 1'b0;
      tick(5);
      wr_reg(`ADDR_CTRL, 16'h0009);
      wr_reg(`ADDR_RATE_DM, 16'h0064);
      wr_reg(`ADDR_RATE_PRIME, 16'h00C8);
      wr_reg(`ADDR_PRIME_LIM, 16'h0003);
      wr_reg(`ADDR_DB_RATE, 16'h0032);
      wr_reg(`ADDR_DB_DWELL, 16'h0002);
      wr_reg(`ADDR_COMMAND, 16'h0004);
      wait_ready(1'b0, 20);
      wait_ready(1'b1, 400);
      rd_reg(`ADDR_STATUS, 16'h0000, 16'h01CF);
      // contact trigger, plc trigger with drawback, serial begin reversed
      for (int i = 0; i < 3; i++) begin
         vol = 1 + $urandom % 4;
         db  = (i == 1) ? 2 : 0;
         slow <= 1'($urandom % 2);
         wr_reg(`ADDR_VOLUME, 16'(vol));
         wr_reg(`ADDR_DB_VOLUME, 16'(db));
         wr_reg(`ADDR_CTRL, (i == 2) ? 16'h000D : 16'h0009);
         if (i == 0) ctc <= 1'b1;
         else if (i == 1) plc <= 1'b1;
         else wr_reg(`ADDR_COMMAND, 16'h0001);
         wait_ready(1'b0, 20);
         @(posedge clk_sys);
         ctc <= 1'b0;
         plc <= 1'b0;
         repeat (2) @(negedge clk_sys);
         chk("motor cmd", {1'b1, i == 2, 16'h0064}, motor_cmd);
         if (db != 0) begin
            nw = 0;
            while (motor_cmd.reverse !== 1'b1 && nw < 400) begin
               @(negedge clk_sys);
               nw++;
            end
            chk("drawback cmd", {2'b11, 16'h0032}, motor_cmd);
         end
         wait_ready(1'b1, 800);
         tot = tot + 16'(vol + db);
         rd_reg(`ADDR_TOTAL, tot, 16'hFFFF);
      end
      wr_reg(`ADDR_CTRL, 16'h0008);
      plc <= 1'b1;
      tick(10);
      @(negedge clk_sys);
      chk("prime idle", 18'h1, {17'h0, ready});
      @(posedge clk_sys);
      plc <= 1'b0;
      wr_reg(`ADDR_COMMAND, 16'h0001);
      wait_ready(1'b0, 20);
      repeat (2) @(negedge clk_sys);
      chk("prime cmd", {2'b10, 16'h00C8}, motor_cmd);
      wait_ready(1'b1, 60);
      chk("prime span", 18'h1, {17'h0, nw > 20 && nw < 34});
      rd_reg(`ADDR_TOTAL, tot, 16'hFFFF);
      wr_reg(`ADDR_CTRL, 16'h000A);
      plc <= 1'b1;
      wait_ready(1'b0, 20);
      repeat (2) @(negedge clk_sys);
      chk("meter cmd", {2'b10, 16'h0064}, motor_cmd);
      tick(40);
      plc <= 1'b0;
      wait_ready(1'b1, 10);
      wr_reg(`ADDR_COMMAND, 16'h0001);
      wait_ready(1'b0, 20);
      wr_reg(`ADDR_COMMAND, 16'h0002);
      wait_ready(1'b1, 10);
      wr_reg(`ADDR_COMMAND, 16'h0001);
      wait_ready(1'b0, 20);
      tick(20);
      empty <= 1'b1;
      wait_ready(1'b1, 10);
      @(posedge clk_sys);
      empty <= 1'b0;
      wr_reg(`ADDR_COMMAND, 16'h0010);
      rd_reg(`ADDR_TOTAL, 16'h0000, 16'hFFFF);
      felse <= 1'b1;
      rd_reg(`ADDR_STATUS, 16'h0004, 16'h0006);
      felse  <= 1'b0;
      mfault <= 1'b1;
      tick(5);
      mfault <= 1'b0;
      tick(5);
      rd_reg(`ADDR_STATUS, 16'h000A, 16'h000B);
      // reference needs no prior reference, so only the fault can refuse it
      wr_reg(`ADDR_COMMAND, 16'h0004);
      tick(4);
      @(negedge clk_sys);
      chk("fault blocks", 18'h1, {17'h0, ready});
      wr_reg(`ADDR_COMMAND, 16'h0008);
      rd_reg(`ADDR_FAULT_ID, 16'h0001, 16'hFFFF);
      rd_reg(`ADDR_STATUS, 16'h0008, 16'h000A);
      tick(4);
      close_out();
   end
endmodule // tb
`default_nettype wire
